/* File: design/irq_agg_pkg.sv */
// constants for the reader interrupt aggregator
// assumes one 8-bit register port driven by the serial host engine
package irq_agg_pkg;

  // register addresses
  localparam logic [7:0] ADDR_MAIN_MASK   = 8'h14;
  localparam logic [7:0] ADDR_TIMER_MASK  = 8'h15;
  localparam logic [7:0] ADDR_ERROR_MASK  = 8'h16;
  localparam logic [7:0] ADDR_MAIN_PEND   = 8'h17;
  localparam logic [7:0] ADDR_TIMER_PEND  = 8'h18;
  localparam logic [7:0] ADDR_ERROR_PEND  = 8'h19;

  // reset and default values
  localparam logic [7:0] MASK_RESET       = 8'h00;
  localparam logic [7:0] PEND_RESET       = 8'h00;
  localparam logic [7:0] RDATA_UNMAPPED   = 8'h00;

  // main mask only keeps bits 7..2; bits 1..0 are unused
  localparam logic [7:0] MAIN_MASK_USED   = 8'hFC;

  // bit positions inside the main registers
  localparam int BIT_OSC   = 7;
  localparam int BIT_LEVEL = 6;
  localparam int BIT_RXS   = 5;
  localparam int BIT_RXE   = 4;
  localparam int BIT_TXE   = 3;
  localparam int BIT_COL   = 2;
  localparam int BIT_TIM   = 1;
  localparam int BIT_ERR   = 0;

  // number of directly latched main events (bits 7..2)
  localparam int MAIN_EVT_W = 6;
  // width of each detail register
  localparam int DETAIL_W   = 8;

endpackage

/* File: design/sticky_flags.sv */
// bank of sticky event flags; set beats clr_all, soft_clr beats set
// assumes set and clear pulses come from logic on the same clock
`timescale 1ns/1ps
module sticky_flags #(
  parameter int W = 8
) (
  input  wire logic         clk_sys,
  input  wire logic         reset_n,
  input  wire logic         soft_clr,
  input  wire logic [W-1:0] set_bits,
  input  wire logic         clr_all,
  output logic      [W-1:0] flags
);

  logic [W-1:0] flags_r;    // latched events
  logic [W-1:0] flags_nxt;  // next value

  // clr_all never eats an event arriving in the same cycle; soft_clr drops it
  assign flags_nxt = soft_clr ? '0 : ((clr_all ? '0 : flags_r) | set_bits);
  assign flags     = flags_r;

  // flag storage
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      flags_r <= '0;
    end
    else
    begin
      flags_r <= flags_nxt;
    end
  end

endmodule

/* File: design/reader_interrupt_aggregator.sv */
// interrupt collection, masking and clear-on-read registers
// assumes a host register port on clk_sys (from the serial engine)
// and one-cycle event pulses or levels from logic on the same clock
`timescale 1ns/1ps

// Functional notes
// - main mask holds six suppress bits 7..2
// - timer/field mask, one suppress bit per source
// - error/wake-up mask, one suppress bit per source
// - all masks reset to zero, also on default
// - oscillator stable after enable sets bit 7
// - receive with FIFO nearly full sets level flag
// - transmit with FIFO nearly empty sets level flag
// - receive start/end, transmit end, collision latch
// - bit 1 summarises timer/field detail register
// - bit 0 summarises error/wake-up detail register
// - main pending register read-only, resets zero
// - main read clears 7..2; summaries clear via detail
// - timer/field detail register read-only, mask order
module reader_interrupt_aggregator (
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  // set-default command, one-cycle pulse
  input  wire logic       set_default,
  // host register port
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // oscillator
  input  wire logic       osc_enable,
  input  wire logic       osc_stable,
  // FIFO water level
  input  wire logic       receiving,
  input  wire logic       transmitting,
  input  wire logic       fifo_nearly_full,
  input  wire logic       fifo_nearly_empty,
  // framing events, one-cycle pulses
  input  wire logic       rx_start_evt,
  input  wire logic       rx_end_evt,
  input  wire logic       tx_end_evt,
  input  wire logic       bit_col_evt,
  // detail sources, one-cycle pulses in register bit order
  input  wire logic [7:0] timer_field_evt,
  input  wire logic [7:0] error_wakeup_evt,
  // interrupt to the host
  output logic            irq
);

  // mask registers
  logic [7:0] main_irq_mask_r;        // main suppress bits
  logic [7:0] main_irq_mask_nxt;
  logic [7:0] timer_field_irq_mask_r; // timer/field suppress bits
  logic [7:0] timer_field_irq_mask_nxt;
  logic [7:0] error_wakeup_irq_mask_r;// error/wake-up suppress bits
  logic [7:0] error_wakeup_irq_mask_nxt;

  // edge detection state
  logic osc_ready_r;   // last stable-and-enabled level
  logic level_cond_r;  // last water-level condition
  logic [7:0] reg_rdata_r;
  logic [7:0] reg_rdata_nxt;

  // flag bank outputs
  logic [irq_agg_pkg::MAIN_EVT_W-1:0] main_flags;
  logic [irq_agg_pkg::DETAIL_W-1:0]   timer_flags;
  logic [irq_agg_pkg::DETAIL_W-1:0]   error_flags;

  // address match, shared by read and write decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_a);
    hit = (a == ref_a);
  endfunction

  // decoded strobes
  wire wr_main_mask  = reg_wr && hit(reg_addr, irq_agg_pkg::ADDR_MAIN_MASK);
  wire wr_timer_mask = reg_wr && hit(reg_addr, irq_agg_pkg::ADDR_TIMER_MASK);
  wire wr_error_mask = reg_wr && hit(reg_addr, irq_agg_pkg::ADDR_ERROR_MASK);
  wire rd_main_pend  = reg_rd && hit(reg_addr, irq_agg_pkg::ADDR_MAIN_PEND);
  wire rd_timer_pend = reg_rd && hit(reg_addr, irq_agg_pkg::ADDR_TIMER_PEND);
  wire rd_error_pend = reg_rd && hit(reg_addr, irq_agg_pkg::ADDR_ERROR_PEND);

  // oscillator ready edge
  // only a rising ready level counts, so a steady oscillator fires once
  wire osc_ready     = osc_enable && osc_stable;
  wire osc_evt       = osc_ready && !osc_ready_r;

  wire level_rx      = receiving && fifo_nearly_full;
  wire level_tx      = transmitting && fifo_nearly_empty;
  wire level_cond    = level_rx || level_tx;
  // edge, so the host gets one flag per crossing, not one per cycle
  wire level_evt     = level_cond && !level_cond_r;

  wire [irq_agg_pkg::MAIN_EVT_W-1:0] main_set =
    {osc_evt, level_evt, rx_start_evt, rx_end_evt, tx_end_evt, bit_col_evt};

  wire tim_summary   = |timer_flags;
  wire err_summary   = |error_flags;

  // assembled main pending view
  wire [7:0] main_irq_pending = {main_flags, tim_summary, err_summary};

  wire main_active   = |(main_irq_pending[irq_agg_pkg::BIT_OSC:irq_agg_pkg::BIT_COL]
                         & ~main_irq_mask_r[irq_agg_pkg::BIT_OSC:irq_agg_pkg::BIT_COL]);
  wire tim_active    = |(timer_flags & ~timer_field_irq_mask_r);
  wire err_active    = |(error_flags & ~error_wakeup_irq_mask_r);
  // summaries are gated by their detail masks, not the unused main bits
  assign irq         = main_active || tim_active || err_active;

  // main mask write, unused bits held at zero
  assign main_irq_mask_nxt = set_default ? irq_agg_pkg::MASK_RESET :
    wr_main_mask ? (reg_wdata & irq_agg_pkg::MAIN_MASK_USED) : main_irq_mask_r;
  assign timer_field_irq_mask_nxt = set_default ? irq_agg_pkg::MASK_RESET :
    wr_timer_mask ? reg_wdata : timer_field_irq_mask_r;
  assign error_wakeup_irq_mask_nxt = set_default ? irq_agg_pkg::MASK_RESET :
    wr_error_mask ? reg_wdata : error_wakeup_irq_mask_r;

  // read data mux; pending registers accept no write
  assign reg_rdata_nxt =
    hit(reg_addr, irq_agg_pkg::ADDR_MAIN_MASK)  ? main_irq_mask_r :
    hit(reg_addr, irq_agg_pkg::ADDR_TIMER_MASK) ? timer_field_irq_mask_r :
    hit(reg_addr, irq_agg_pkg::ADDR_ERROR_MASK) ? error_wakeup_irq_mask_r :
    hit(reg_addr, irq_agg_pkg::ADDR_MAIN_PEND)  ? main_irq_pending :
    hit(reg_addr, irq_agg_pkg::ADDR_TIMER_PEND) ? timer_flags :
    hit(reg_addr, irq_agg_pkg::ADDR_ERROR_PEND) ? error_flags :
    irq_agg_pkg::RDATA_UNMAPPED;

  assign reg_rdata = reg_rdata_r;

  // mask registers, zero at reset and default
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      main_irq_mask_r         <= irq_agg_pkg::MASK_RESET;
      timer_field_irq_mask_r  <= irq_agg_pkg::MASK_RESET;
      error_wakeup_irq_mask_r <= irq_agg_pkg::MASK_RESET;
    end
    else
    begin
      main_irq_mask_r         <= main_irq_mask_nxt;
      timer_field_irq_mask_r  <= timer_field_irq_mask_nxt;
      error_wakeup_irq_mask_r <= error_wakeup_irq_mask_nxt;
    end
  end

  // edge history and read data capture
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      osc_ready_r  <= 1'b0;
      level_cond_r <= 1'b0;
      reg_rdata_r  <= irq_agg_pkg::PEND_RESET;
    end
    else
    begin
      osc_ready_r  <= osc_ready;
      level_cond_r <= level_cond;
      // hold last answer between reads
      if (reg_rd)
      begin
        reg_rdata_r <= reg_rdata_nxt;
      end
    end
  end

  sticky_flags #(
    .W (irq_agg_pkg::MAIN_EVT_W)
  ) u_main_flags (
    .clk_sys  (clk_sys),
    .reset_n  (reset_n),
    .soft_clr (set_default),
    .set_bits (main_set),
    .clr_all  (rd_main_pend),
    .flags    (main_flags)
  );

  // timer/field detail, cleared by its own read
  sticky_flags #(
    .W (irq_agg_pkg::DETAIL_W)
  ) u_timer_flags (
    .clk_sys  (clk_sys),
    .reset_n  (reset_n),
    .soft_clr (set_default),
    .set_bits (timer_field_evt),
    .clr_all  (rd_timer_pend),
    .flags    (timer_flags)
  );

  // error/wake-up detail, cleared by its own read
  sticky_flags #(
    .W (irq_agg_pkg::DETAIL_W)
  ) u_error_flags (
    .clk_sys  (clk_sys),
    .reset_n  (reset_n),
    .soft_clr (set_default),
    .set_bits (error_wakeup_evt),
    .clr_all  (rd_error_pend),
    .flags    (error_flags)
  );

  // checks on the design's own outputs
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  a_main_mask_unused: assert property (
    main_irq_mask_r[1:0] == 2'h0)
    else $error("main mask unused bits not zero");

  a_timer_mask_write: assert property (
    (wr_timer_mask && !set_default) |=> timer_field_irq_mask_r == $past(reg_wdata))
    else $error("timer mask write lost");

  a_error_mask_write: assert property (
    (wr_error_mask && !set_default) |=> error_wakeup_irq_mask_r == $past(reg_wdata))
    else $error("error mask write lost");

  a_default_clears_mask: assert property (
    set_default |=> (main_irq_mask_r == 8'h00 && timer_field_irq_mask_r == 8'h00
                     && error_wakeup_irq_mask_r == 8'h00))
    else $error("set default left a mask bit set");

  a_osc_sets_flag: assert property (
    (osc_enable && osc_stable && !$past(osc_enable && osc_stable) && !set_default)
      |=> main_irq_pending[irq_agg_pkg::BIT_OSC])
    else $error("oscillator ready did not set flag");

  a_level_sets_flag: assert property (
    ($rose(receiving && fifo_nearly_full) && !set_default)
      |=> main_irq_pending[irq_agg_pkg::BIT_LEVEL])
    else $error("receive water level not flagged");

  a_col_set_wins: assert property (
    (bit_col_evt && rd_main_pend && !set_default)
      |=> main_irq_pending[irq_agg_pkg::BIT_COL])
    else $error("collision lost on concurrent clear");

  a_tim_summary: assert property (
    main_irq_pending[irq_agg_pkg::BIT_TIM] == (timer_flags != 8'h00))
    else $error("timer summary mismatch");

  a_main_read_clear: assert property (
    (rd_main_pend && main_set == 6'h00 && !rd_timer_pend && timer_field_evt == 8'h00
     && !set_default)
      |=> (main_irq_pending[7:2] == 6'h00
           && main_irq_pending[irq_agg_pkg::BIT_TIM] == $past(tim_summary)))
    else $error("main read clear wrong");

  a_irq_follows_mask: assert property (
    irq == (|(main_irq_pending[7:2] & ~main_irq_mask_r[7:2])
            || |(timer_flags & ~timer_field_irq_mask_r)
            || |(error_flags & ~error_wakeup_irq_mask_r)))
    else $error("irq does not match unmasked pending");

  a_read_latency: assert property (
    (reg_rd && hit(reg_addr, irq_agg_pkg::ADDR_TIMER_PEND))
      |=> reg_rdata == $past(timer_flags))
    else $error("timer detail read data wrong");

  // write path of the main mask, unused bits forced low
  a_main_mask_write: assert property (
    (wr_main_mask && !set_default)
      |=> main_irq_mask_r == ($past(reg_wdata) & irq_agg_pkg::MAIN_MASK_USED))
    else $error("main mask write lost");

  // transmit side of the water-level flag, receive side idle before
  a_tx_level_flag: assert property (
    ($rose(transmitting && fifo_nearly_empty) && !$past(receiving && fifo_nearly_full)
     && !set_default)
      |=> main_irq_pending[irq_agg_pkg::BIT_LEVEL])
    else $error("transmit water level not flagged");

  // error summary drops once its detail register is read
  a_err_summary_clear: assert property (
    (rd_error_pend && error_wakeup_evt == 8'h00 && !set_default)
      |=> !main_irq_pending[irq_agg_pkg::BIT_ERR])
    else $error("error summary survived detail read");

  // timer summary drops once its detail register is read
  a_tim_summary_clear: assert property (
    (rd_timer_pend && timer_field_evt == 8'h00 && !set_default)
      |=> !main_irq_pending[irq_agg_pkg::BIT_TIM])
    else $error("timer summary survived detail read");

  // a main read must leave the timer detail flags alone
  a_detail_kept: assert property (
    (rd_main_pend && !rd_timer_pend && !set_default)
      |=> timer_flags == ($past(timer_flags) | $past(timer_field_evt)))
    else $error("main read disturbed timer detail");

  // set-default empties the whole main pending view
  a_default_clears_pend: assert property (
    set_default |=> main_irq_pending == irq_agg_pkg::PEND_RESET)
    else $error("set default left a pending bit");

  // with every flag gone the interrupt line must fall
  a_irq_drops_default: assert property (
    set_default |=> !irq)
    else $error("irq still high after set default");

endmodule

/* File: dv/host_model.sv */
// host microcontroller side of the register port, single transfers
// assumes a zero-wait register port sampled on rising clk_sys
`timescale 1ns/1ps
module host_model (
  input  wire logic       clk_sys,
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  // idle values at time zero
  initial
  begin
    reg_addr  = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_wdata = 8'h00;
  end

  // one write; released data shows the inverse so a stale sample is seen
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
    reg_wdata <= ~d;
  endtask

  // one read; data is taken once the taking edge has landed
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask
endmodule

/* File: dv/reader_interrupt_aggregator_tb_top.sv */
// self-checking bench: integer model of masks and pending flags
// assumes host_model drives the register port of the aggregator
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fails++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module reader_interrupt_aggregator_tb_top;
  logic       clk_sys = 1'b0;
  logic       reset_n = 1'b0;
  logic       set_default = 1'b0;
  logic       osc_enable = 1'b0;
  logic       osc_stable = 1'b0;
  logic       receiving = 1'b0;
  logic       transmitting = 1'b0;
  logic       nfull = 1'b0;
  logic       nempty = 1'b0;
  logic [3:0] mev = 4'h0;                 // main events, bits 5..2
  logic [7:0] tfe = 8'h00;
  logic [7:0] ewe = 8'h00;
  wire  [7:0] reg_addr, reg_wdata, reg_rdata;
  wire        reg_wr, reg_rd, irq;
  logic [7:0] mm, tm, em, mp, tp, ep, d; // model masks and pending
  int         fails = 0;
  int         cmp_count = 0;

  always #5 clk_sys = ~clk_sys;

  host_model i_host (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  reader_interrupt_aggregator i_dut (.clk_sys(clk_sys), .reset_n(reset_n),
    .set_default(set_default), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .osc_enable(osc_enable),
    .osc_stable(osc_stable), .receiving(receiving), .transmitting(transmitting),
    .fifo_nearly_full(nfull), .fifo_nearly_empty(nempty), .rx_start_evt(mev[3]),
    .rx_end_evt(mev[2]), .tx_end_evt(mev[1]), .bit_col_evt(mev[0]),
    .timer_field_evt(tfe), .error_wakeup_evt(ewe), .irq(irq));

  // masks gate only the irq, never the latching
  function automatic logic exp_irq();
    return |(mp[7:2] & ~mm[7:2]) | |(tp & ~tm) | |(ep & ~em);
  endfunction

  // read, compare with the model, then apply the clear-on-read side effect
  task automatic rdc(input logic [7:0] a);
    logic [7:0] e;
    case (a)
      irq_agg_pkg::ADDR_MAIN_MASK:  e = mm;
      irq_agg_pkg::ADDR_TIMER_MASK: e = tm;
      irq_agg_pkg::ADDR_ERROR_MASK: e = em;
      irq_agg_pkg::ADDR_MAIN_PEND:  e = {mp[7:2], |tp, |ep};
      irq_agg_pkg::ADDR_TIMER_PEND: e = tp;
      irq_agg_pkg::ADDR_ERROR_PEND: e = ep;
      default:                      e = 8'h00;
    endcase
    i_host.rd(a, d);
    `CHK(d, e)
    if (a == 8'h17) mp = 8'h00;
    if (a == 8'h18) tp = 8'h00;
    if (a == 8'h19) ep = 8'h00;
    // pending irq follows the unmasked flags
    `CHK(irq, exp_irq())
  endtask

  // write through the host and mirror into the model
  task automatic wrm(input logic [7:0] a, input logic [7:0] v);
    i_host.wr(a, v);
    if (a == 8'h14) mm = v & 8'hFC;
    if (a == 8'h15) tm = v;
    if (a == 8'h16) em = v;
  endtask

  // one-cycle event pulses, checked one edge later
  task automatic pulse(input logic [3:0] m, input logic [7:0] t, input logic [7:0] e);
    @(posedge clk_sys);
    mev <= m;
    tfe <= t;
    ewe <= e;
    @(posedge clk_sys);
    mev <= 4'h0;
    tfe <= 8'h00;
    ewe <= 8'h00;
    mp = mp | {m, 2'b00};
    tp = tp | t;
    ep = ep | e;
    #1;
    `CHK(irq, exp_irq())
  endtask

  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // guard against a hang
  initial
  begin
    #100000;
    fails++;
    summarize();
  end

  initial
  begin
    {mm, tm, em, mp, tp, ep} = '0;
    void'($urandom(47768));
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    for (int a = 8'h14; a <= 8'h1A; a++) rdc(8'(a));
    repeat (3)
    begin
      wrm(8'h14, 8'($urandom));
      wrm(8'h15, 8'($urandom));
      wrm(8'h16, 8'($urandom));
      wrm(8'h17, 8'($urandom));
      wrm(8'h18, 8'($urandom));
      wrm(8'h19, 8'($urandom));
      for (int a = 8'h14; a <= 8'h19; a++) rdc(8'(a));
      for (int i = 0; i < 4; i++)
      begin
        pulse(4'(1 << i), 8'h00, 8'h00);
        rdc(8'h17);
        rdc(8'h17);
      end
      pulse(4'h0, 8'($urandom), 8'h00);
      rdc(8'h17);
      rdc(8'h17);
      rdc(8'h18);
      pulse(4'h0, 8'h00, 8'($urandom));
      rdc(8'h17);
      rdc(8'h19);
      rdc(8'h17);
      // event and clearing read share one edge: the set must win
      fork
        pulse(4'h1, 8'h00, 8'h00);
        i_host.rd(8'h17, d);
      join
      `CHK(d, 8'h00)
      rdc(8'h17);
    end
    wrm(8'h14, 8'h00);
    @(posedge clk_sys);
    osc_enable <= 1'b1;
    osc_stable <= 1'b1;
    transmitting <= 1'b1;
    nfull <= 1'b1;
    repeat (2) @(posedge clk_sys);
    mp[7] = 1'b1;
    rdc(8'h17);
    rdc(8'h17);
    @(posedge clk_sys);
    nempty <= 1'b1;
    repeat (2) @(posedge clk_sys);
    mp[6] = 1'b1;
    rdc(8'h17);
    @(posedge clk_sys);
    transmitting <= 1'b0;
    nfull <= 1'b0;
    @(posedge clk_sys);
    receiving <= 1'b1;
    nfull <= 1'b1;
    repeat (2) @(posedge clk_sys);
    mp[6] = 1'b1;
    rdc(8'h17);
    wrm(8'h15, 8'h5A);
    pulse(4'hF, 8'hFF, 8'hFF);
    @(posedge clk_sys);
    set_default <= 1'b1;
    @(posedge clk_sys);
    set_default <= 1'b0;
    {mm, tm, em, mp, tp, ep} = '0;
    for (int a = 8'h14; a <= 8'h19; a++) rdc(8'(a));
    summarize();
  end
endmodule
